// File: hdl/vec_reloc_pkg.sv
// Package: register map, field positions, reset values and timing counts for vector relocation
package vec_reloc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the register bus)
  // ----------------------------------------------------------------
  localparam logic [11:0] GEN_IRQ_CTRL_OFS = 12'h000; // General interrupt control
  localparam logic [11:0] RELOC_STATUS_OFS = 12'h004; // Fuse and sequence status

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CHG_EN_BIT   = 0;                    // vector_change_enable
  localparam int VSEL_BIT     = 1;                    // vector_table_select
  localparam int EXT_IRQ2_BIT = 5;                    // ext_irq2_enable
  localparam int EXT_IRQ0_BIT = 6;                    // ext_irq0_enable
  localparam int EXT_IRQ1_BIT = 7;                    // ext_irq1_enable
  localparam logic [7:0] GEN_IRQ_CTRL_RST = 8'h00;    // Reset value of the control register

  // ----------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------
  localparam int ST_SIZE_LSB   = 0;                   // boot_size_fuses, two bits
  localparam int ST_RST_FUSE   = 2;                   // boot_reset_fuse
  localparam int ST_APP_LOCK   = 3;                   // app_boot_lock_bit
  localparam int ST_BOOT_LOCK  = 4;                   // boot_section_lock_bit
  localparam int ST_MASK       = 5;                   // Sequence mask active
  localparam int ST_WINDOW     = 6;                   // Change window open
  localparam int ST_IRQ_BLOCK  = 7;                   // Interrupts blocked

  // ----------------------------------------------------------------
  // Fuse convention and flash geometry
  // ----------------------------------------------------------------
  localparam logic FUSE_PROGRAMMED = 1'b0;            // A fuse or lock bit reads 0 when programmed
  localparam int   FLASH_AW        = 14;              // Word address width of program flash
  localparam logic [13:0] APP_RESET_ADDR = 14'h0000;  // Reset address in the application section
  localparam logic [13:0] VEC_STEP       = 14'h0002;  // Words between two vectors
  localparam logic [13:0] BOOT_START_SZ0 = 14'h3800;  // Boot start, 4K byte section
  localparam logic [13:0] BOOT_START_SZ1 = 14'h3c00;  // Boot start, size code 1
  localparam logic [13:0] BOOT_START_SZ2 = 14'h3e00;  // Boot start, size code 2
  localparam logic [13:0] BOOT_START_SZ3 = 14'h3f00;  // Boot start, size code 3

  // ----------------------------------------------------------------
  // Timing counts in system clock cycles
  // ----------------------------------------------------------------
  localparam int WINDOW_CYCLES = 4;                   // Change-enable window length
  localparam int MASK_CYCLES   = 4;                   // Mask length when no select write follows
  localparam int NUM_VECTORS   = 21;                  // Reset plus twenty interrupt vectors

endpackage

// File: hdl/vec_seq_if.sv
// Interface: handshake between the register front end and the change-sequence timer
`timescale 1ns/1ps
`default_nettype none
interface vec_seq_if;
  logic start;        // Enable write accepted, one-cycle pulse
  logic sel_write;    // Select write accepted inside the window, one-cycle pulse
  logic instr_done;   // Core finished an instruction, one-cycle pulse
  logic window_open;  // Change window open (reads back as change enable)
  logic mask_active;  // Sequence mask currently applied
  logic nxt_mask;     // Value the mask takes at the next edge

  modport ctrl (output start, output sel_write, output instr_done,
                input window_open, input mask_active, input nxt_mask);
  modport seq  (input start, input sel_write, input instr_done,
                output window_open, output mask_active, output nxt_mask);
endinterface
`default_nettype wire

// File: hdl/vec_change_seq.sv
// Change-sequence timer: opens the select window and holds the interrupt mask
`timescale 1ns/1ps
`default_nettype none
module vec_change_seq #(
  parameter int WINDOW_LEN = vec_reloc_pkg::WINDOW_CYCLES,
  parameter int MASK_LEN   = vec_reloc_pkg::MASK_CYCLES
) (
  input  wire logic clk,
  input  wire logic srst,
  vec_seq_if.seq    sq
);

  // ----------------------------------------------------------------
  // State and counter
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {IDLE, WINDOW, HOLD} seq_state_t;

  seq_state_t  state_ff;     // Sequence phase
  seq_state_t  nxt_state;    // Next phase
  logic [2:0]  cnt_ff;       // Cycles left in the window
  logic [2:0]  nxt_cnt;      // Next count
  logic        mask_ff;      // Mask flop
  logic        nxt_mask;     // Next mask

  localparam logic [2:0] WIN_LOAD  = 3'(WINDOW_LEN - 1);
  localparam logic [2:0] MASK_LOAD = 3'(MASK_LEN - 1);

  // Next-state logic; a fresh enable write restarts the window
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_mask  = mask_ff;
    case (state_ff)
      IDLE: begin
        // Nothing pending
        nxt_mask = 1'b0;
      end
      WINDOW: begin
        if (sq.sel_write) begin
          // Select written: close window, keep mask past next instruction
          nxt_state = HOLD;
        end else if (cnt_ff == 3'h0) begin
          // No select write: release after the counted cycles
          nxt_state = IDLE;
          nxt_mask  = 1'b0;
        end else begin
          nxt_cnt = cnt_ff - 3'h1; // Counts system clock cycles
        end
      end
      HOLD: begin
        // Mask held until the core completes the following instruction
        if (sq.instr_done) begin
          nxt_state = IDLE;
          nxt_mask  = 1'b0;
        end
      end
      default: begin
        nxt_state = IDLE;
        nxt_mask  = 1'b0;
      end
    endcase
    if (sq.start) begin
      // Masking begins in the very cycle the enable is set
      nxt_state = WINDOW;
      nxt_cnt   = (WIN_LOAD > MASK_LOAD) ? WIN_LOAD : MASK_LOAD;
      nxt_mask  = 1'b1;
    end
  end

  // Phase and count registers
  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= IDLE;
      cnt_ff   <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // Mask register
  always_ff @(posedge clk) begin
    if (srst) begin
      mask_ff <= 1'b0;
    end else begin
      mask_ff <= nxt_mask;
    end
  end

  assign sq.window_open = (state_ff == WINDOW);
  assign sq.mask_active = mask_ff;
  assign sq.nxt_mask    = nxt_mask;

endmodule
`default_nettype wire

// File: hdl/vec_reloc.sv
// Interrupt vector relocation: control register, vector addresses and interrupt blocking
//
// Behaviour
// - Select zero: vectors start after reset vector
// - Select one: vectors at boot section start
// - Mask from enable until instruction after select
// - Without select write, mask four cycles only
// - Masking leaves the core's global flag alone
// - Enable clears after four cycles or select
// - Boot vectors, app lock: block in application
// - App vectors, boot lock: block in boot
// - Select bit 1, enable bit 0, reset zero
// - Reset address boot start or zero by fuse
// - Relocated vectors two words apart from start
// - Reset fuse one unprogrammed, zero programmed
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module vec_reloc #(
  parameter logic [13:0] BOOT_START_0 = vec_reloc_pkg::BOOT_START_SZ0,
  parameter logic [13:0] BOOT_START_1 = vec_reloc_pkg::BOOT_START_SZ1,
  parameter logic [13:0] BOOT_START_2 = vec_reloc_pkg::BOOT_START_SZ2,
  parameter logic [13:0] BOOT_START_3 = vec_reloc_pkg::BOOT_START_SZ3
) (
  input  wire logic        clk,                    // System clock
  input  wire logic        srst,                   // Synchronous reset, active high
  // APB slave
  input  wire logic        psel,                   // Slave select
  input  wire logic        penable,                // Access phase
  input  wire logic        pwrite,                 // Write direction
  input  wire logic [11:0] paddr,                  // Byte address
  input  wire logic [31:0] pwdata,                 // Write data
  input  wire logic [3:0]  pstrb,                  // Byte strobes
  output logic      [31:0] prdata,                 // Read data
  output logic             pready,                 // Transfer done
  output logic             pslverr,                // Unmapped address
  // Fuses and lock bits, static
  input  wire logic        boot_reset_fuse,        // 0 = programmed
  input  wire logic [1:0]  boot_size_fuses,        // Boot section size code
  input  wire logic        app_boot_lock_bit,      // 0 = programmed
  input  wire logic        boot_section_lock_bit,  // 0 = programmed
  // Core side
  input  wire logic [13:0] exec_pc,                // Word address being executed
  input  wire logic        instr_done,             // Instruction completed, pulse
  input  wire logic [4:0]  irq_num,                // Vector number to look up
  output logic      [13:0] reset_address,          // Where execution starts after reset
  output logic      [13:0] vector_base,            // Address of the reset slot of the table
  output logic      [13:0] irq_vector_addr,        // Address of vector irq_num
  output logic      [2:0]  ext_irq_enables,        // {ext_irq1, ext_irq0, ext_irq2} enables
  output logic             irq_block               // Interrupts blocked this cycle
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Boot section start for a size code; used for vectors, reset and locks
  function automatic logic [13:0] boot_start_of(input logic [1:0] sz);
    logic [13:0] a;
    a = BOOT_START_0;
    if (sz == 2'h1) begin
      a = BOOT_START_1;
    end else if (sz == 2'h2) begin
      a = BOOT_START_2;
    end else if (sz == 2'h3) begin
      a = BOOT_START_3;
    end
    return a;
  endfunction

  // True when a word address falls inside the boot section
  function automatic logic in_boot(input logic [13:0] pc, input logic [1:0] sz);
    return pc >= boot_start_of(sz);
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  vec_seq_if   seq_bus ();                 // Link to the sequence timer

  logic        vsel_ff;                    // vector_table_select
  logic [2:0]  ext_en_ff;                  // External interrupt enables
  logic [31:0] prdata_ff;                  // Read data register
  logic        pready_ff;                  // Ready register
  logic        pslverr_ff;                 // Error register
  logic [13:0] reset_addr_ff;              // Reset address register
  logic [13:0] vec_base_ff;                // Table base register
  logic [13:0] irq_vec_ff;                 // Looked-up vector register
  logic        irq_block_ff;               // Blocking register
  logic        acc;                        // Access completes at this edge
  logic        ctrl_hit;                   // Control register addressed
  logic        stat_hit;                   // Status register addressed
  logic        ctrl_wr;                    // Low byte of control written
  logic        start_wr;                   // Enable written to one
  logic        sel_wr;                     // Select write inside the window
  logic        nxt_vsel;                   // Select after this edge
  logic        lock_block;                 // Lock-bit blocking term
  logic [7:0]  ctrl_rd;                    // Control readback
  logic [7:0]  stat_rd;                    // Status readback
  logic [13:0] boot_start;                 // Current boot section start

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------

  // One wait state: ready rises in the second access cycle, so every
  // write lands on the edge where the master sees ready
  // Only the low byte lane matters: both registers are eight bits wide,
  // so a write with pstrb[0] low leaves every control bit untouched
  assign acc      = psel & penable & pready_ff;
  assign ctrl_hit = (paddr == vec_reloc_pkg::GEN_IRQ_CTRL_OFS);
  assign stat_hit = (paddr == vec_reloc_pkg::RELOC_STATUS_OFS);
  assign ctrl_wr  = acc & pwrite & ctrl_hit & pstrb[0];

  // Step one of the change sequence: enable written to one
  assign start_wr = ctrl_wr & pwdata[vec_reloc_pkg::CHG_EN_BIT];

  // Step two: enable written zero while the window is open
  assign sel_wr   = ctrl_wr & ~pwdata[vec_reloc_pkg::CHG_EN_BIT] & seq_bus.window_open;

  // Select takes the written value only on a window write
  assign nxt_vsel = sel_wr ? pwdata[vec_reloc_pkg::VSEL_BIT] : vsel_ff;

  assign boot_start = boot_start_of(boot_size_fuses);

  // ----------------------------------------------------------------
  // Sequence timer
  // ----------------------------------------------------------------
  assign seq_bus.start      = start_wr;
  assign seq_bus.sel_write  = sel_wr;    // Clears the window at once
  assign seq_bus.instr_done = instr_done;

  vec_change_seq #(
    .WINDOW_LEN (vec_reloc_pkg::WINDOW_CYCLES),
    .MASK_LEN   (vec_reloc_pkg::MASK_CYCLES)
  ) u_seq (
    .clk  (clk),
    .srst (srst),
    .sq   (seq_bus)
  );

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------

  // Vector select bit; reset puts the table in the application section
  always_ff @(posedge clk) begin
    if (srst) begin
      vsel_ff <= vec_reloc_pkg::GEN_IRQ_CTRL_RST[vec_reloc_pkg::VSEL_BIT];
    end else begin
      vsel_ff <= nxt_vsel;
    end
  end

  // External interrupt enables are plain read/write bits
  always_ff @(posedge clk) begin
    if (srst) begin
      ext_en_ff <= 3'h0;
    end else if (ctrl_wr) begin
      ext_en_ff <= {pwdata[vec_reloc_pkg::EXT_IRQ1_BIT],
                    pwdata[vec_reloc_pkg::EXT_IRQ0_BIT],
                    pwdata[vec_reloc_pkg::EXT_IRQ2_BIT]};
    end
  end

  // Control readback; the enable bit is the live window flag
  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[vec_reloc_pkg::CHG_EN_BIT]   = seq_bus.window_open;
    ctrl_rd[vec_reloc_pkg::VSEL_BIT]     = vsel_ff;
    ctrl_rd[vec_reloc_pkg::EXT_IRQ2_BIT] = ext_en_ff[0];
    ctrl_rd[vec_reloc_pkg::EXT_IRQ0_BIT] = ext_en_ff[1];
    ctrl_rd[vec_reloc_pkg::EXT_IRQ1_BIT] = ext_en_ff[2];
  end

  // Status readback shows fuses and the sequence state
  always_comb begin
    stat_rd = 8'h00;
    stat_rd[vec_reloc_pkg::ST_SIZE_LSB +: 2]  = boot_size_fuses;
    stat_rd[vec_reloc_pkg::ST_RST_FUSE]       = boot_reset_fuse;
    stat_rd[vec_reloc_pkg::ST_APP_LOCK]       = app_boot_lock_bit;
    stat_rd[vec_reloc_pkg::ST_BOOT_LOCK]      = boot_section_lock_bit;
    stat_rd[vec_reloc_pkg::ST_MASK]           = seq_bus.mask_active;
    stat_rd[vec_reloc_pkg::ST_WINDOW]         = seq_bus.window_open;
    stat_rd[vec_reloc_pkg::ST_IRQ_BLOCK]      = irq_block_ff;
  end

  // Ready pulses for one cycle in the second access cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= psel & penable & ~pready_ff;
    end
  end

  // Read data and error are loaded together with ready
  always_ff @(posedge clk) begin
    if (srst) begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (psel & penable & ~pready_ff) begin
      if (ctrl_hit) begin
        prdata_ff  <= {24'h00_0000, ctrl_rd};
        pslverr_ff <= 1'b0;
      end else if (stat_hit) begin
        prdata_ff  <= {24'h00_0000, stat_rd};
        pslverr_ff <= 1'b0;
      end else begin
        // Unmapped: zero data and an error
        prdata_ff  <= 32'h0000_0000;
        pslverr_ff <= 1'b1;
      end
    end else begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Vector addresses
  // ----------------------------------------------------------------

  // Reset address follows the reset fuse, zero meaning programmed
  always_ff @(posedge clk) begin
    if (srst) begin
      reset_addr_ff <= 14'h0000;
    end else if (boot_reset_fuse == vec_reloc_pkg::FUSE_PROGRAMMED) begin
      reset_addr_ff <= boot_start;
    end else begin
      reset_addr_ff <= vec_reloc_pkg::APP_RESET_ADDR;
    end
  end

  // Table base moves with the select bit; it tracks the next value so the
  // core sees the new table on the same edge the bit changes
  always_ff @(posedge clk) begin
    if (srst) begin
      vec_base_ff <= 14'h0000;
    end else if (nxt_vsel) begin
      vec_base_ff <= boot_start;
    end else begin
      vec_base_ff <= vec_reloc_pkg::APP_RESET_ADDR;
    end
  end

  // Vector n sits n steps of two words above the base; out-of-range
  // numbers give the base itself
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_vec_ff <= 14'h0000;
    end else if (irq_num < 5'(vec_reloc_pkg::NUM_VECTORS)) begin
      irq_vec_ff <= (nxt_vsel ? boot_start : vec_reloc_pkg::APP_RESET_ADDR)
                  + 14'(vec_reloc_pkg::VEC_STEP * irq_num);
    end else begin
      irq_vec_ff <= nxt_vsel ? boot_start : vec_reloc_pkg::APP_RESET_ADDR;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt blocking
  // ----------------------------------------------------------------

  // Lock bits block interrupts in the section that does not hold the table;
  // the fetch address is taken as presented, one cycle of lag
  // A change of the size fuses moves the section boundary one edge later
  always_comb begin
    lock_block = 1'b0;
    if (nxt_vsel && (app_boot_lock_bit == vec_reloc_pkg::FUSE_PROGRAMMED) &&
        !in_boot(exec_pc, boot_size_fuses)) begin
      lock_block = 1'b1;
    end else if (!nxt_vsel && (boot_section_lock_bit == vec_reloc_pkg::FUSE_PROGRAMMED) &&
                 in_boot(exec_pc, boot_size_fuses)) begin
      lock_block = 1'b1;
    end
  end

  // Blocking is a separate gate toward the core; the global enable flag in
  // the core's status register is never written from here
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_block_ff <= 1'b0;
    end else begin
      irq_block_ff <= seq_bus.nxt_mask | lock_block;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata          = prdata_ff;
  assign pready          = pready_ff;
  assign pslverr         = pslverr_ff;
  assign reset_address   = reset_addr_ff;
  assign vector_base     = vec_base_ff;
  assign irq_vector_addr = irq_vec_ff;
  assign ext_irq_enables = ext_en_ff;
  assign irq_block       = irq_block_ff;

endmodule
`default_nettype wire

// File: test/reloc_chk_assertions.sv
// Checker: port-level assertions for the vector relocation block
`timescale 1ns/1ps
`default_nettype none
module reloc_chk (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        boot_reset_fuse,
  input wire logic [1:0]  boot_size_fuses,
  input wire logic        app_boot_lock_bit,
  input wire logic        boot_section_lock_bit,
  input wire logic [13:0] exec_pc,
  input wire logic [13:0] reset_address,
  input wire logic [13:0] vector_base,
  input wire logic [2:0]  ext_irq_enables,
  input wire logic        irq_block
);
  // Boot section start for the size code on the fuses
  wire logic [13:0] bs = (boot_size_fuses == 2'h0) ? vec_reloc_pkg::BOOT_START_SZ0 :
    (boot_size_fuses == 2'h1) ? vec_reloc_pkg::BOOT_START_SZ1 :
    (boot_size_fuses == 2'h2) ? vec_reloc_pkg::BOOT_START_SZ2 : vec_reloc_pkg::BOOT_START_SZ3;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Accepted control write, and one that also opens the change window
  sequence s_ctl_wr;
    pready && pwrite && paddr == 12'h000 && pstrb[0];
  endsequence
  sequence s_en_wr;
    s_ctl_wr ##0 pwdata[0];
  endsequence
  a_ready_wait: assert property ($rose(psel && penable) |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  a_err_addr: assert property (pready |-> pslverr == (paddr != 12'h000 && paddr != 12'h004))
    else $error("pslverr does not match address");
  a_idle_quiet: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read data or error outside answer");
  a_ext_en: assert property (s_ctl_wr |=> ext_irq_enables == $past(pwdata[7:5]))
    else $error("external enables not written");
  a_mask_len: assert property (s_en_wr |=> irq_block [*4])
    else $error("mask shorter than window");
  a_reset_addr: assert property (!$past(srst) |->
    reset_address == ($past(boot_reset_fuse) ? 14'h0000 : $past(bs))) else $error("bad reset address");
  a_block_app: assert property (!$past(srst) && vector_base != 14'h0 &&
    $past(!app_boot_lock_bit && exec_pc < bs) |-> irq_block) else $error("app not blocked");
  a_block_boot: assert property (!$past(srst) && vector_base == 14'h0 &&
    $past(!boot_section_lock_bit && exec_pc >= bs) |-> irq_block) else $error("boot not blocked");
endmodule
`default_nettype wire

// File: test/core_model.sv
// Partner: processor core that moves the program counter and retires instructions
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input  wire logic        clk,
  output logic      [13:0] exec_pc,
  output logic             instr_done,
  output logic      [4:0]  irq_num
);
  // Core starts idle at the bottom of flash
  initial begin
    exec_pc = 14'h0000;
    instr_done = 1'b0;
    irq_num = 5'h00;
  end
  // Jump and look up a vector; two edges let the registered answer land
  task automatic go(input logic [13:0] pc, input logic [4:0] n);
    exec_pc <= pc;
    irq_num <= n;
    repeat (2) @(posedge clk);
  endtask
  // Complete the instruction after the select write, one-cycle pulse
  task automatic retire();
    instr_done <= 1'b1;
    @(posedge clk);
    instr_done <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// File: test/tb_top.sv
// Testbench: register rows, change sequence, lock blocking and reset vectors
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk = 1'b0, srst = 1'b1;               // Clock, reset held two edges
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  pstrb = 4'hf;                           // Low byte enabled except in the final low-lane-off write
  logic        pready, pslverr, er;
  logic        rfuse = 1'b0, app_lock = 1'b1, boot_lock = 1'b1; // Reset fuse programmed
  logic [1:0]  size = 2'h0;                            // 4K byte boot section
  logic [13:0] exec_pc, reset_address, vector_base, irq_vector_addr;
  logic [4:0]  irq_num;
  logic [2:0]  ext_irq_enables;
  logic        instr_done, irq_block;
  int          mismatches = 0, n_compared = 0, cycles = 0;
  typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e;} row_t;
  row_t rows [5] = '{'{1'b0, 12'h000, 32'h0, 32'h00, 1'b0}, '{1'b0, 12'h004, 32'h0, 32'h18, 1'b0},
    '{1'b1, 12'h000, 32'he2, 32'h0, 1'b0}, '{1'b0, 12'h000, 32'h0, 32'he0, 1'b0},
    '{1'b0, 12'h008, 32'h0, 32'h0, 1'b1}};
  always #2 clk = ~clk;
  // Hang guard: the whole run needs under a hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      close_out();
    end
  end
  vec_reloc DUT (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .boot_reset_fuse(rfuse), .boot_size_fuses(size),
    .app_boot_lock_bit(app_lock), .boot_section_lock_bit(boot_lock), .exec_pc(exec_pc),
    .instr_done(instr_done), .irq_num(irq_num), .reset_address(reset_address),
    .vector_base(vector_base), .irq_vector_addr(irq_vector_addr),
    .ext_irq_enables(ext_irq_enables), .irq_block(irq_block));
  core_model u_core (.clk(clk), .exec_pc(exec_pc), .instr_done(instr_done), .irq_num(irq_num));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // APB transfer; psel stays up so a following transfer may start at once
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1); // Only the hang guard ends a wait
    rd = prdata;
    er = pslverr;
  endtask
  task automatic rel();
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic close_out();
    if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk(er, rows[i].e);
      if (!rows[i].w) chk(rd, rows[i].q);
    end
    rel();
    chk(ext_irq_enables, 3'h7);
    chk(vector_base, 14'h0000);
    chk(reset_address, 14'h3800);
    // Enable alone: mask for four cycles, then late select is ignored
    apb(1'b1, 12'h000, 32'h01);
    rel();
    chk(irq_block, 1'b1);
    repeat (4) @(posedge clk);
    chk(irq_block, 1'b0);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 12'h000, 32'h02);
    rel();
    repeat (2) @(posedge clk);
    chk(vector_base, 14'h0000);
    // Back-to-back enable and select: table moves to the boot section
    apb(1'b1, 12'h000, 32'h01);
    apb(1'b1, 12'h000, 32'h02);
    rel();
    repeat (5) @(posedge clk);
    chk(irq_block, 1'b1);
    chk(vector_base, 14'h3800);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h02);
    rel();
    u_core.go(14'h0000, 5'd1);
    chk(irq_vector_addr, 14'h3802);
    u_core.go(14'h0000, 5'd20);
    chk(irq_vector_addr, 14'h3828);
    u_core.retire();
    chk(irq_block, 1'b0);
    app_lock <= 1'b0;
    u_core.go(14'h0100, 5'd0);
    chk(irq_block, 1'b1);
    u_core.go(14'h3900, 5'd0);
    chk(irq_block, 1'b0);
    app_lock <= 1'b1;
    // Move the table back, then the boot lock blocks boot-section code
    apb(1'b1, 12'h000, 32'h01);
    apb(1'b1, 12'h000, 32'h00);
    rel();
    u_core.retire();
    u_core.go(14'h0000, 5'd1);
    chk(vector_base, 14'h0000);
    chk(irq_vector_addr, 14'h0002);
    boot_lock <= 1'b0;
    u_core.go(14'h3900, 5'd0);
    chk(irq_block, 1'b1);
    u_core.go(14'h0100, 5'd0);
    chk(irq_block, 1'b0);
    size <= 2'h1; // Other size code; an out-of-range vector gives the base
    u_core.go(14'h0000, 5'd21);
    chk(reset_address, 14'h3c00);
    chk(irq_vector_addr, 14'h0000);
    // Second reset with the reset fuse unprogrammed
    rfuse <= 1'b1;
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    chk(reset_address, 14'h0000);
    pstrb <= 4'he; // Low lane off: the control write must not land
    apb(1'b1, 12'h000, 32'he2);
    pstrb <= 4'hf;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    close_out();
  end
endmodule
bind vec_reloc reloc_chk u_chk (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .boot_reset_fuse(boot_reset_fuse),
  .boot_size_fuses(boot_size_fuses), .app_boot_lock_bit(app_boot_lock_bit),
  .boot_section_lock_bit(boot_section_lock_bit), .exec_pc(exec_pc),
  .reset_address(reset_address), .vector_base(vector_base),
  .ext_irq_enables(ext_irq_enables), .irq_block(irq_block));
`default_nettype wire
